// *** hw/uar_rx_recovery.sv ***
/*
 Receive recovery of an asynchronous serial port with its frame FIFO.
 Assumes sample_tick_i pulses at 16x or 8x the baud rate from the divider.
*/

// Shift-register FIFO; the head entry is a flop.
module uar_fifo #(
	parameter int unsigned WIDTH = 11,
	parameter int unsigned DEPTH = 8
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rstn_i,
	// Fill side.
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// Drain side.
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int unsigned CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [CW-1:0] count_q;
	logic [CW-1:0] count_d;
	logic [CW-1:0] wr_idx;
	logic valid_q;
	logic push;
	logic pop;

	// Handshakes and write slot.
	assign in_ready_o = (count_q != CW'(DEPTH));
	assign push = in_valid_i && in_ready_o;
	assign pop = valid_q && out_ready_i;
	assign wr_idx = pop ? count_q - 1'b1 : count_q;
	assign out_valid_o = valid_q;
	assign out_data_o = mem_q[0];

	// Occupancy count.
	always_comb begin
		count_d = count_q;
		if (push && !pop) begin
			count_d = count_q + 1'b1;
		end else if (pop && !push) begin
			count_d = count_q - 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			count_q <= '0;
			valid_q <= 1'b0;
		end else begin
			count_q <= count_d;
			valid_q <= (count_d != '0);
		end
	end

	// Each entry shifts toward the head on a pop.
	for (genvar i = 0; i < DEPTH; i++) begin : g_ent
		logic [WIDTH-1:0] nxt;
		if (i == DEPTH - 1) begin : g_last
			assign nxt = '0;
		end else begin : g_mid
			assign nxt = mem_q[i+1];
		end
		always_ff @(posedge clk_i) begin
			if (!rstn_i) begin
				mem_q[i] <= '0;
			end else if (push && wr_idx == CW'(i)) begin
				mem_q[i] <= in_data_i;
			end else if (pop) begin
				mem_q[i] <= nxt;
			end
		end
	end
endmodule // uar_fifo

module uar_rx_recovery (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rstn_i,
	// Rate and format.
	input wire logic sample_tick_i,
	input wire logic double_speed_sel_i,
	input wire logic [3:0] frame_bits_i,
	// Serial line.
	input wire logic serial_rx_in_i,
	// Received frames.
	output logic frame_valid_o,
	input wire logic frame_ready_i,
	output uar_pkg::uar_frame_s frame_o,
	// Status.
	output logic frame_error_flag_o
);
	import uar_pkg::*;

	uar_state_e state_q;
	logic rx_m_q;
	logic rx_s_q;
	logic rx_prev_q;
	logic dbl_q;
	logic [3:0] nbits_q;
	logic [3:0] bit_idx_q;
	logic [4:0] cnt_q;
	logic [1:0] votes_q;
	logic [9:0] data_q;
	logic pend_q;
	uar_frame_s frm_q;
	logic fe_q;
	logic fifo_ready;
	logic [4:0] osr_w;
	logic [4:0] vfirst_w;
	logic [4:0] vlast_w;
	logic run;
	logic vote_now;
	logic last_vote;
	logic vote_bit;
	logic start_seen;
	logic bit_end;

	// Majority of three samples.
	function automatic logic maj3(input logic a, input logic b, input logic c);
		maj3 = (a & b) | (a & c) | (b & c);
	endfunction

	// Keeps the length inside five to ten bits.
	function automatic logic [3:0] bits_clamp(input logic [3:0] b);
		if (b < UAR_BITS_MIN) begin
			bits_clamp = UAR_BITS_MIN;
		end else if (b > UAR_BITS_MAX) begin
			bits_clamp = UAR_BITS_MAX;
		end else begin
			bits_clamp = b;
		end
	endfunction

	// Two-flop synchroniser on the line.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			rx_m_q <= UAR_LINE_IDLE;
			rx_s_q <= UAR_LINE_IDLE;
		end else begin
			rx_m_q <= serial_rx_in_i;
			rx_s_q <= rx_m_q;
		end
	end

	// Mode-dependent sample count and vote window.
	assign osr_w = dbl_q ? UAR_OVS_DOUBLE : UAR_OVS_NORMAL;
	assign vfirst_w = dbl_q ? UAR_VOTE_FIRST_DOUBLE : UAR_VOTE_FIRST_NORMAL;
	assign vlast_w = vfirst_w + UAR_VOTE_SPAN;
	assign run = sample_tick_i && (state_q != UAR_IDLE); // Local rate error rests on the tick divider
	assign vote_now = run && cnt_q >= vfirst_w && cnt_q <= vlast_w;
	assign last_vote = run && cnt_q == vlast_w;
	assign vote_bit = maj3(votes_q[1], votes_q[0], rx_s_q);
	assign bit_end = run && cnt_q == osr_w;

	// Edge search stalls while a frame waits for buffer room.
	assign start_seen = sample_tick_i && state_q == UAR_IDLE && !pend_q && rx_prev_q && !rx_s_q;

	// Previous sample for edge detection.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			rx_prev_q <= UAR_LINE_IDLE;
		end else if (sample_tick_i) begin
			rx_prev_q <= rx_s_q;
		end
	end

	// Frame sequencer.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			state_q <= UAR_IDLE;
		end else begin
			case (state_q)
				UAR_IDLE: begin
					if (start_seen) begin
						state_q <= UAR_START;
					end
				end
				UAR_START: begin
					if (last_vote && vote_bit) begin
						state_q <= UAR_IDLE;
					end else if (bit_end) begin
						state_q <= UAR_DATA;
					end
				end
				UAR_DATA: begin
					if (bit_end && bit_idx_q == nbits_q - 4'h1) begin
						state_q <= UAR_STOP;
					end
				end
				UAR_STOP: begin
					if (!dbl_q && last_vote) begin
						state_q <= UAR_IDLE;
					end else if (dbl_q && run && cnt_q == vlast_w + UAR_STOP_HOLD_DOUBLE) begin
						state_q <= UAR_IDLE;
					end
				end
				default: begin
					state_q <= UAR_IDLE;
				end
			endcase
		end
	end

	// Mode and length are held for the whole frame.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			dbl_q <= 1'b0;
			nbits_q <= UAR_BITS_MIN;
		end else if (start_seen) begin
			dbl_q <= double_speed_sel_i;
			nbits_q <= bits_clamp(frame_bits_i);
		end
	end

	// Sample state counter, restarted by each start edge.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			cnt_q <= UAR_CNT_RESET;
		end else if (start_seen) begin
			cnt_q <= 5'h02; // The start tick was sample one, so the next is two
		end else if (bit_end) begin
			cnt_q <= 5'h01;
		end else if (run) begin
			cnt_q <= cnt_q + 5'h01;
		end
	end

	// Vote sample history.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			votes_q <= '0;
		end else if (vote_now) begin
			votes_q <= {votes_q[0], rx_s_q};
		end
	end

	// Bit index and data assembly, least significant bit first.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			bit_idx_q <= '0;
			data_q <= '0;
		end else if (start_seen) begin
			bit_idx_q <= '0;
			data_q <= '0;
		end else begin
			if (state_q == UAR_DATA && last_vote) begin
				data_q[bit_idx_q] <= vote_bit;
			end
			if (state_q == UAR_DATA && bit_end) begin
				bit_idx_q <= bit_idx_q + 4'h1;
			end
		end
	end

	// Completed frame waits here until the FIFO takes it.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			pend_q <= 1'b0;
			frm_q <= '0;
			fe_q <= 1'b0;
		end else if (state_q == UAR_STOP && last_vote) begin
			pend_q <= 1'b1;
			frm_q <= '{frame_error: !vote_bit, data: data_q};
			fe_q <= !vote_bit;
		end else if (pend_q && fifo_ready) begin
			pend_q <= 1'b0;
		end
	end

	assign frame_error_flag_o = fe_q;

	// Frame buffer.
	uar_fifo #(
		.WIDTH($bits(uar_frame_s)),
		.DEPTH(UAR_FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.in_valid_i(pend_q),
		.in_ready_o(fifo_ready),
		.in_data_i(frm_q),
		.out_valid_o(frame_valid_o),
		.out_ready_i(frame_ready_i),
		.out_data_o(frame_o)
	);

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);

	sequence s_stop_vote;
		state_q == UAR_STOP && last_vote;
	endsequence

	chk_sync_two_flop: assert property (rx_s_q == $past(serial_rx_in_i, 2))
		else $error("Line synchroniser is not two stages.");
	chk_start_edge_one: assert property (start_seen |=> state_q == UAR_START && cnt_q == 5'h02)
		else $error("Start edge was not counted as sample one.");
	chk_start_reject: assert property (state_q == UAR_START && last_vote && vote_bit |=> state_q == UAR_IDLE)
		else $error("Noisy start bit was not rejected.");
	chk_vote_window: assert property (vote_now |-> (dbl_q ? cnt_q inside {5'h04, 5'h05, 5'h06}
		: cnt_q inside {5'h08, 5'h09, 5'h0a}))
		else $error("Vote sample outside the centre window.");
	chk_mid_sample: assert property (run && cnt_q == (dbl_q ? UAR_VOTE_MID_DOUBLE : UAR_VOTE_MID_NORMAL)
		|-> vote_now ##1 (votes_q[0] == $past(rx_s_q)))
		else $error("Middle vote sample misplaced.");
	chk_bit_wrap: assert property (bit_end |=> cnt_q == 5'h01 && $past(cnt_q) == (dbl_q ? 5'h08 : 5'h10))
		else $error("Bit did not span its sample states.");
	chk_frame_error: assert property (s_stop_vote |=> pend_q && fe_q == !$past(vote_bit))
		else $error("Frame error does not follow the stop vote.");
	chk_stop_release: assert property (s_stop_vote and !dbl_q |=> state_q == UAR_IDLE)
		else $error("Normal speed did not free the edge search.");
	chk_frame_length: assert property (state_q == UAR_DATA ##1 state_q == UAR_STOP
		|-> $past(bit_idx_q) == nbits_q - 4'h1 && nbits_q >= 4'h5 && nbits_q <= 4'ha)
		else $error("Frame length out of range.");
endmodule // uar_rx_recovery

// *** hw/uar_pkg.sv ***
/*
 Package of the asynchronous receive recovery block.
 Holds sample counts, vote positions, frame limits and the carried frame type.
 Assumes one 200 MHz clock and an oversample enable made elsewhere.
*/
package uar_pkg;

	// Samples per bit in normal and double speed.
	localparam logic [4:0] UAR_OVS_NORMAL = 5'h10;
	localparam logic [4:0] UAR_OVS_DOUBLE = 5'h08;

	// First and middle vote samples per mode.
	localparam logic [4:0] UAR_VOTE_FIRST_NORMAL = 5'h08;
	localparam logic [4:0] UAR_VOTE_FIRST_DOUBLE = 5'h04;
	localparam logic [4:0] UAR_VOTE_MID_NORMAL = 5'h09;
	localparam logic [4:0] UAR_VOTE_MID_DOUBLE = 5'h05;

	// Offset of the last vote sample from the first.
	localparam logic [4:0] UAR_VOTE_SPAN = 5'h02;

	// Extra samples held after the stop vote in double speed.
	localparam logic [4:0] UAR_STOP_HOLD_DOUBLE = 5'h01;

	// Data plus parity length limits.
	localparam logic [3:0] UAR_BITS_MIN = 4'h5;
	localparam logic [3:0] UAR_BITS_MAX = 4'ha;

	// Frame buffer depth.
	localparam int unsigned UAR_FIFO_DEPTH = 8;

	// Reset values.
	localparam logic UAR_LINE_IDLE = 1'b1;
	localparam logic [4:0] UAR_CNT_RESET = 5'h00;

	// Receiver states.
	typedef enum logic [1:0] {
		UAR_IDLE,
		UAR_START,
		UAR_DATA,
		UAR_STOP
	} uar_state_e;

	// One received frame.
	typedef struct packed {
		logic frame_error;
		logic [9:0] data;
	} uar_frame_s;

endpackage

// *** dv/uar_tx_model.sv ***
/*
 Model of the remote serial transmitter.
 Assumes the bench makes tick_i, one pulse per oversample of the receiver.
*/
module uar_tx_model (
	// Clock and sample tick.
	input wire logic clk_i,
	input wire logic tick_i,
	// Serial line.
	output logic line_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// The line idles high.
	initial line_o = 1'b1;

	// Drives a level for a number of ticks; bit time is exact, so the rate error is zero.
	task automatic hold(input logic v, input int k);
		line_o <= v;
		repeat (k) @(posedge clk_i iff tick_i);
	endtask

	// Sends a start bit, n bits least significant first, then the stop level.
	task automatic send(input logic [9:0] d, input int n, input int spb, input logic stp, input int stop_len);
		hold(1'b0, spb);
		for (int i = 0; i < n; i++) begin
			hold(d[i], spb);
		end
		hold(stp, stop_len);
	endtask
endmodule // uar_tx_model

// *** dv/uar_rx_recovery_test.sv ***
/*
 Self-checking bench of the receive recovery block.
 Assumes the transmitter model and one 200 MHz clock; ticks come every second cycle.
*/
module uar_rx_recovery_test;
	timeunit 1ns;
	timeprecision 1ps;
	import uar_pkg::*;

	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic sample_tick_i = 1'b0;
	logic double_speed_sel_i = 1'b0;
	logic [3:0] frame_bits_i = 4'h8;
	logic serial_rx_in_i;
	logic frame_valid_o;
	logic frame_ready_i = 1'b0;
	uar_frame_s frame_o;
	logic frame_error_flag_o;
	int errors = 0;
	int n_checks = 0;
	int cycles = 0;

	uar_rx_recovery uut (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.sample_tick_i(sample_tick_i),
		.double_speed_sel_i(double_speed_sel_i),
		.frame_bits_i(frame_bits_i),
		.serial_rx_in_i(serial_rx_in_i),
		.frame_valid_o(frame_valid_o),
		.frame_ready_i(frame_ready_i),
		.frame_o(frame_o),
		.frame_error_flag_o(frame_error_flag_o)
	);

	uar_tx_model tx (
		.clk_i(clk_i),
		.tick_i(sample_tick_i),
		.line_o(serial_rx_in_i)
	);

	// Clock of 5 ns period.
	always #2.5 clk_i = ~clk_i;

	// Oversample tick every second cycle, and a ceiling on the run.
	always @(posedge clk_i) begin
		sample_tick_i <= ~sample_tick_i;
		cycles++;
		if (cycles == 30000) begin
			errors++;
			finish_test();
		end
	end

	// Compares a value seen against the expected one.
	task automatic check(input string what, input logic [10:0] seen, input logic [10:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Expected word: error bit over the n received bits.
	function automatic logic [10:0] fr(input logic fe, input logic [9:0] d, input int n);
		return {fe, d & ((10'h001 << n) - 10'h001)};
	endfunction

	// Waits for the head word, checks it and pops it.
	task automatic pop(input logic [10:0] exp);
		int k;
		k = 0;
		@(negedge clk_i);
		while (frame_valid_o !== 1'b1 && k < 2000) begin
			@(negedge clk_i);
			k++;
		end
		check("valid", {10'h000, frame_valid_o}, 11'h001);
		check("frame", frame_o, exp);
		@(posedge clk_i);
		frame_ready_i <= 1'b1;
		@(posedge clk_i);
		frame_ready_i <= 1'b0;
	endtask

	// One normal-speed frame of eight bits with a chosen stop level.
	task automatic t_one(input logic [9:0] d, input logic stp);
		tx.send(d, 8, 16, stp, 16);
		tx.hold(1'b1, 8);
		@(negedge clk_i);
		check("flag", {10'h000, frame_error_flag_o}, {10'h000, ~stp});
		pop(fr(~stp, d, 8));
		$display("frame test done");
	endtask

	// A short low is noise; a low over samples 8 and 9 is a start.
	task automatic t_glitch();
		tx.hold(1'b0, 7);
		tx.hold(1'b1, 200);
		@(negedge clk_i);
		check("noise", {10'h000, frame_valid_o}, 11'h000);
		@(posedge clk_i);
		tx.hold(1'b0, 9);
		tx.hold(1'b1, 24);
		pop(fr(1'b0, 10'h0ff, 8));
		$display("noise test done");
	endtask

	// Bit zero has samples 8 and 9 low, bit one samples 10 and 11 low; only 8, 9 and 10 may vote.
	task automatic t_vote();
		double_speed_sel_i <= 1'b0;
		frame_bits_i <= 4'h8;
		@(posedge clk_i);
		tx.hold(1'b0, 16);
		tx.hold(1'b1, 7);
		tx.hold(1'b0, 2);
		tx.hold(1'b1, 7);
		tx.hold(1'b1, 9);
		tx.hold(1'b0, 2);
		tx.hold(1'b1, 5);
		tx.hold(1'b1, 112);
		pop(fr(1'b0, 10'h0fe, 8));
		$display("vote test done");
	endtask

	// Two frames with the shortest gap taken at normal speed and a full stop bit at double speed.
	task automatic t_pair(input logic dbl, input int n, input logic [9:0] d0, input logic [9:0] d1);
		int spb;
		spb = dbl ? 8 : 16;
		double_speed_sel_i <= dbl;
		frame_bits_i <= 4'(n);
		@(posedge clk_i);
		tx.send(d0, n, spb, 1'b1, dbl ? 8 : 10);
		tx.send(d1, n, spb, 1'b1, spb);
		pop(fr(1'b0, d0, n));
		pop(fr(1'b0, d1, n));
		$display("pair test done");
	endtask

	// Fills the buffer while nothing drains; the frame after the pending one is lost.
	task automatic t_full();
		double_speed_sel_i <= 1'b0;
		frame_bits_i <= 4'h8;
		@(posedge clk_i);
		for (int i = 0; i < 10; i++) tx.send(10'(i), 8, 16, 1'b1, 16);
		for (int i = 0; i < 9; i++) pop(fr(1'b0, 10'(i), 8));
		repeat (40) @(negedge clk_i);
		check("empty", {10'h000, frame_valid_o}, 11'h000);
		@(posedge clk_i);
		$display("buffer test done");
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic finish_test();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Main sequence.
	initial begin
		repeat (16) @(posedge clk_i);
		rstn_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		t_one(10'h0a5, 1'b1);
		t_one(10'h03c, 1'b0);
		t_glitch();
		t_vote();
		t_pair(1'b1, 10, 10'h2b5, 10'h14a);
		t_pair(1'b0, 5, 10'h01f, 10'h00a);
		t_full();
		finish_test();
	end
endmodule // uar_rx_recovery_test
